// file: core/pixel_array_addressing_control.sv
// Pixel array addressing, row control and end-of-scan logic
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
// Function
// - Start value reaches pointer only on preset
// - Column clock fall advances column pointer
// - Output holds while column clock low
// - Start registers keep contents across frames
// - Row enable low inhibits the pixel array
// - Zeroing input routes dark level, unity gain
// - Each shift register flags its end
// - Row reset acts on chosen row pointer
// - Row enable selects chosen row pointer
// - Side choice 1 left read, 0 right
// - Latch strobe low tracks, high holds
// - End flag low one period after last
// - Row pointers advance on row clock fall
module pixel_array_addressing_control (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor pins from the timing controller
  input wire logic [8:0] start_addr,
  input wire logic col_start_latch,
  input wire logic row_start_latch,
  input wire logic col_clock,
  input wire logic col_preset_n,
  input wire logic readrow_clock,
  input wire logic readrow_preset_n,
  input wire logic resetrow_clock,
  input wire logic resetrow_preset_n,
  input wire logic row_enable,
  input wire logic row_reset,
  input wire logic side_left,
  input wire logic amp_zero,
  // Outputs
  output logic col_end_flag_n,
  output logic readrow_end_flag_n,
  output logic resetrow_end_flag_n,
  output logic [8:0] col_ptr,
  output logic [8:0] row_sel_addr,
  output logic row_sel_active,
  output logic row_rst_active,
  output logic amp_zero_mode,
  output logic out_hold
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pin order, top bit first: nine address bits, both latch strobes,
  // clock and preset of column, read row and reset row, then row
  // enable, row reset, side choice and zeroing; bit 0 is a spare
  localparam int NP = 22;
  logic [NP-1:0] pin_in;
  logic [NP-1:0] meta_r;
  logic [NP-1:0] sync_r;
  logic [NP-1:0] prev_r;

  assign pin_in = {start_addr, col_start_latch, row_start_latch, col_clock,
                   col_preset_n, readrow_clock, readrow_preset_n,
                   resetrow_clock, resetrow_preset_n, row_enable,
                   row_reset, side_left, amp_zero, 1'b0};

  // Two stages; the second stage feeds logic, and a third copy of it feeds edge detection
  // Reset to idle pin levels: cleared stages would show a false clock
  // edge and a false preset right after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= roi_addr_pkg::PIN_IDLE;
      sync_r <= roi_addr_pkg::PIN_IDLE;
      prev_r <= roi_addr_pkg::PIN_IDLE;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Synchronised pin levels, and the shift clocks one cycle earlier
  logic [8:0] s_addr;
  logic s_cl;
  logic s_rl;
  logic s_cclk;
  logic s_cpn;
  logic s_rrclk;
  logic s_rrpn;
  logic s_rsclk;
  logic s_rspn;
  logic s_en;
  logic s_rst;
  logic s_left;
  logic s_zero;
  logic p_cclk;
  logic p_rrclk;
  logic p_rsclk;

  assign s_addr = sync_r[21:13];
  assign s_cl = sync_r[12];
  assign s_rl = sync_r[11];
  assign s_cclk = sync_r[10];
  assign s_cpn = sync_r[9];
  assign s_rrclk = sync_r[8];
  assign s_rrpn = sync_r[7];
  assign s_rsclk = sync_r[6];
  assign s_rspn = sync_r[5];
  assign s_en = sync_r[4];
  assign s_rst = sync_r[3];
  assign s_left = sync_r[2];
  assign s_zero = sync_r[1];
  assign p_cclk = prev_r[10];
  assign p_rrclk = prev_r[8];
  assign p_rsclk = prev_r[6];

  // Edge detection on the controller-made clocks
  // Found two cycles late; pulses under one cycle may be lost
  logic cclk_fall;
  logic cclk_rise;
  logic rrclk_fall;
  logic rsclk_fall;
  assign cclk_fall = p_cclk && !s_cclk;
  assign cclk_rise = !p_cclk && s_cclk;
  assign rrclk_fall = p_rrclk && !s_rrclk;
  assign rsclk_fall = p_rsclk && !s_rsclk;

  // True when a pointer sits on the last place of its register
  function automatic logic at_last(input logic [8:0] p,
                                   input logic [8:0] last);
    at_last = (p == last);
  endfunction

  // Pointer step with wrap at the array edge
  function automatic logic [8:0] step(input logic [8:0] p,
                                      input logic [8:0] last);
    step = at_last(p, last) ? 9'h000 : 9'(p + 9'h001);
  endfunction

  // ----------------------------------------------------------------
  // Start registers
  // ----------------------------------------------------------------
  logic [8:0] col_start_r;
  logic [8:0] row_start_r;

  // Transparent while strobe low, held when high; never cleared per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_start_r <= roi_addr_pkg::START_RST;
      row_start_r <= roi_addr_pkg::START_RST;
    end else begin
      if (!s_cl) col_start_r <= s_addr;
      if (!s_rl) row_start_r <= s_addr;
    end
  end

  // ----------------------------------------------------------------
  // Shift registers (pointers)
  // ----------------------------------------------------------------
  // One pointer per shift register; both row pointers share one start
  logic [8:0] col_ptr_r;
  logic [8:0] readrow_ptr_r;
  logic [8:0] resetrow_ptr_r;

  // Preset takes priority; pointer only moves to start here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_ptr_r <= roi_addr_pkg::START_RST;
    end else if (!s_cpn) begin
      col_ptr_r <= col_start_r;
    end else if (cclk_fall) begin
      col_ptr_r <= step(col_ptr_r, roi_addr_pkg::LAST_COL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readrow_ptr_r <= roi_addr_pkg::START_RST;
    end else if (!s_rrpn) begin
      readrow_ptr_r <= row_start_r;
    end else if (rrclk_fall) begin
      readrow_ptr_r <= step(readrow_ptr_r, roi_addr_pkg::LAST_ROW);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resetrow_ptr_r <= roi_addr_pkg::START_RST;
    end else if (!s_rspn) begin
      resetrow_ptr_r <= row_start_r;
    end else if (rsclk_fall) begin
      resetrow_ptr_r <= step(resetrow_ptr_r, roi_addr_pkg::LAST_ROW);
    end
  end

  // ----------------------------------------------------------------
  // End-of-scan flags
  // ----------------------------------------------------------------
  // Low for one shift clock period after the step past the last place;
  // a preset leaves the flag alone, so a cut scan still ends cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_end_flag_n <= 1'b1;
    end else if (cclk_fall) begin
      col_end_flag_n <=
        !at_last(col_ptr_r, roi_addr_pkg::LAST_COL);
    end
  end

  // Read row flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readrow_end_flag_n <= 1'b1;
    end else if (rrclk_fall) begin
      readrow_end_flag_n <=
        !at_last(readrow_ptr_r, roi_addr_pkg::LAST_ROW);
    end
  end

  // Reset row flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resetrow_end_flag_n <= 1'b1;
    end else if (rsclk_fall) begin
      resetrow_end_flag_n <=
        !at_last(resetrow_ptr_r, roi_addr_pkg::LAST_ROW);
    end
  end

  // ----------------------------------------------------------------
  // Control register written by software
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;
  // Write lands at the access edge; read data is fetched at setup
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= roi_addr_pkg::CTRL_RST;
    end else if (wr_en && paddr == roi_addr_pkg::OFF_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Row control and output stage
  // ----------------------------------------------------------------
  logic array_on;
  logic zero_on;
  assign array_on = s_en && ctrl_r[roi_addr_pkg::CTRL_ARRAY_EN];
  assign zero_on = s_zero && ctrl_r[roi_addr_pkg::CTRL_ZERO_EN];

  // Side choice picks which row pointer drives select and reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_sel_addr <= roi_addr_pkg::START_RST;
    end else begin
      row_sel_addr <= s_left ? readrow_ptr_r : resetrow_ptr_r;
    end
  end

  // Row enable low blocks the array; zeroing cuts the array off the
  // amplifier, so no row is selected while it lasts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_sel_active <= 1'b0;
      row_rst_active <= 1'b0;
      amp_zero_mode <= 1'b0;
    end else begin
      row_sel_active <= array_on && !zero_on;
      row_rst_active <= array_on && s_rst;
      amp_zero_mode <= zero_on;
    end
  end

  // Pixel output updates only after column clock rises, held while low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_ptr <= roi_addr_pkg::START_RST;
      out_hold <= 1'b1;
    end else begin
      if (cclk_rise) col_ptr <= col_ptr_r;
      out_hold <= !s_cclk;
    end
  end

  // ----------------------------------------------------------------
  // APB read path: one wait-free access, data registered at setup
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic bad_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    bad_nxt = 1'b0;
    case (paddr)
      roi_addr_pkg::OFF_CTRL: rd_nxt = {30'h0, ctrl_r};
      roi_addr_pkg::OFF_COL_START: rd_nxt = {23'h0, col_start_r};
      roi_addr_pkg::OFF_ROW_START: rd_nxt = {23'h0, row_start_r};
      roi_addr_pkg::OFF_COL_PTR: rd_nxt = {23'h0, col_ptr_r};
      roi_addr_pkg::OFF_ROW_PTR:
        rd_nxt = {7'h0, resetrow_ptr_r, 7'h0, readrow_ptr_r};
      roi_addr_pkg::OFF_STATUS:
        rd_nxt = {27'h0, s_left, out_hold, amp_zero_mode,
                  row_rst_active, row_sel_active};
      default: bad_nxt = 1'b1;
    endcase
  end

  // Ready in the access cycle only: every transfer takes one wait-free
  // access, so the master never sees a stretched phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Read data fetched at setup; it stays until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_en ? rd_nxt : 32'h0000_0000;
    end
  end

  // Error stands with ready only; a held error would taint later words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && bad_nxt;
    end
  end

endmodule

// file: shared/roi_addr_pkg.sv
// Shared constants for the pixel array addressing and row control block
package roi_addr_pkg;

  // ------------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam logic [8:0] LAST_COL = 9'h1FF;
  localparam logic [8:0] LAST_ROW = 9'h1FF;

  // ------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_COL_START = 12'h004;
  localparam logic [11:0] OFF_ROW_START = 12'h008;
  localparam logic [11:0] OFF_COL_PTR = 12'h00C;
  localparam logic [11:0] OFF_ROW_PTR = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;

  // ------------------------------------------------------------------
  // Control register fields and reset value
  // ------------------------------------------------------------------
  localparam int CTRL_ARRAY_EN = 0;
  localparam int CTRL_ZERO_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // ------------------------------------------------------------------
  // Status register fields
  // ------------------------------------------------------------------
  localparam int ST_ROW_SEL = 0;
  localparam int ST_ROW_RST = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_SIDE = 4;

  localparam logic [8:0] START_RST = 9'h000;

  // Idle pin levels: strobes, shift clocks, presets and row enable high
  localparam logic [21:0] PIN_IDLE = 22'h00_1FF0;

endpackage

// file: tb/addr_ctl_asserts.sv
// Checker for row control, the read row end flag, output hold and APB answer timing
`timescale 1ns/1ps
module addr_ctl_asserts (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic col_clock,
  input logic readrow_clock,
  input logic readrow_preset_n,
  input logic resetrow_clock,
  input logic resetrow_preset_n,
  input logic side_left,
  input logic row_enable,
  input logic row_reset,
  input logic amp_zero,
  input logic readrow_end_flag_n,
  input logic [8:0] row_sel_addr,
  input logic row_sel_active,
  input logic row_rst_active,
  input logic amp_zero_mode,
  input logic out_hold
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------------------------------------------------------------
  // Bus answer: one wait-free access cycle
  // -----------------------------------------------------------------
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_with_ready: assert property (pslverr |-> pready && penable)
    else $error("error without ready");
  // -----------------------------------------------------------------
  // Pin levels, five samples allow for the synchroniser
  // -----------------------------------------------------------------
  chk_enable_inhibit: assert property (
    (!row_enable)[*5] |-> !row_sel_active && !row_rst_active)
    else $error("array active while disabled");
  chk_reset_idle: assert property (
    (!row_reset)[*5] |-> !row_rst_active)
    else $error("row reset without input");
  chk_zero_idle: assert property (
    (!amp_zero)[*5] |-> !amp_zero_mode)
    else $error("zeroing without input");
  chk_zero_disc: assert property (
    amp_zero_mode[*2] |-> !row_sel_active)
    else $error("row selected while zeroing");
  chk_hold_low: assert property (
    (!col_clock)[*5] |-> out_hold)
    else $error("output not held");
  chk_hold_high: assert property (
    col_clock[*5] |-> !out_hold)
    else $error("output held while clock high");
  // Without a falling shift clock, a preset or a side change nothing may move
  chk_flag_steady: assert property (
    (readrow_clock && readrow_preset_n)[*8] |-> $stable(readrow_end_flag_n))
    else $error("end flag moved without clock");
  chk_ptr_steady: assert property (
    (readrow_clock && readrow_preset_n && resetrow_clock &&
     resetrow_preset_n && $stable(side_left))[*8] |-> $stable(row_sel_addr))
    else $error("row pointer moved without clock");
endmodule

// file: tb/sensor_ctl_model.sv
// Timing controller model driving the sensor's clocks and strobes
`timescale 1ns/1ps
module sensor_ctl_model (
  input wire logic pclk,
  output logic [8:0] start_addr,
  output logic col_start_latch,
  output logic row_start_latch,
  output logic col_clock,
  output logic col_preset_n,
  output logic readrow_clock,
  output logic readrow_preset_n,
  output logic resetrow_clock,
  output logic resetrow_preset_n,
  output logic row_enable,
  output logic row_reset,
  output logic side_left,
  output logic amp_zero
);
  logic [2:0] clk_r;
  logic [2:0] pre_n_r;
  assign {resetrow_clock, readrow_clock, col_clock} = clk_r;
  assign {resetrow_preset_n, readrow_preset_n, col_preset_n} = pre_n_r;
  // Idle levels from time zero; enable held high for normal work
  initial begin
    clk_r = 3'h7;
    pre_n_r = 3'h7;
    {col_start_latch, row_start_latch} = 2'h3;
    start_addr = 9'h000;
    {row_enable, row_reset, side_left, amp_zero} = 4'ha;
  end
  // Six cycles per step: short pulses would be lost in the synchroniser
  task automatic tick();
    repeat (6) @(posedge pclk);
  endtask
  // Bus first, strobe tracks then holds, then the bus is let go
  task automatic load(input logic row, input logic [8:0] a);
    start_addr <= a;
    tick();
    if (row) row_start_latch <= 1'b0;
    else col_start_latch <= 1'b0;
    tick();
    {col_start_latch, row_start_latch} <= 2'h3;
    tick();
    start_addr <= ~a;
  endtask
  // Preset only while the shift clock idles high, after the load
  task automatic preset(input int w);
    pre_n_r[w] <= 1'b0;
    tick();
    pre_n_r[w] <= 1'b1;
    tick();
  endtask
  task automatic step(input int w);
    clk_r[w] <= 1'b0;
    tick();
    clk_r[w] <= 1'b1;
    tick();
  endtask
  // Sets enable, reset, side and zeroing pins together, then waits one step
  task automatic set_ctl(input logic [3:0] v);
    {row_enable, row_reset, side_left, amp_zero} <= v;
    tick();
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the pixel array addressing block
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, col_start_latch, row_start_latch;
  logic col_clock, col_preset_n, readrow_clock, readrow_preset_n;
  logic resetrow_clock, resetrow_preset_n, row_enable, row_reset;
  logic side_left, amp_zero, col_end_flag_n, readrow_end_flag_n;
  logic resetrow_end_flag_n, row_sel_active, row_rst_active;
  logic amp_zero_mode, out_hold;
  logic [8:0] start_addr, col_ptr, row_sel_addr, a, rd_p, rs_p;
  logic [1:0] c;
  int n_fail, check_count, cyc;
  always #12.5 pclk = ~pclk;
  pixel_array_addressing_control u_dut (.*);
  sensor_ctl_model u_ctl (.*);
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Held until pready is seen high; the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // Row outputs from pins {enable, reset, side, zero} and control bits
  function automatic logic [2:0] act(input logic [3:0] p, logic [1:0] k);
    return {p[3] & k[0] & !(p[0] & k[1]), p[3] & k[0] & p[2], p[0] & k[1]};
  endfunction
  // Next pointer place: one on, back to zero after the last
  function automatic logic [8:0] nxt(input logic [8:0] p, l);
    return (p == l) ? 9'h000 : 9'(p + 9'h001);
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(49278));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    u_ctl.tick();
    apb(0, roi_addr_pkg::OFF_CTRL, 0);
    check("ctrl", q, 32'(roi_addr_pkg::CTRL_RST));
    apb(1, 12'h0200, 32'hffff_ffff);
    check("unmapped_err", 32'(e), 32'h0000_0001);
    check("unmapped_rd", q, 32'h0000_0000);
    a = 9'($urandom_range(1, 509));
    u_ctl.load(1, a);
    check("no_preset", row_sel_addr, 9'h000);
    apb(0, roi_addr_pkg::OFF_ROW_START, 0);
    check("row_start", q, 32'(a));
    u_ctl.preset(1);
    check("preset", row_sel_addr, a);
    u_ctl.step(1);
    check("step", row_sel_addr, a + 9'h001);
    u_ctl.preset(1);
    check("kept", row_sel_addr, a);
    u_ctl.preset(2);
    u_ctl.step(2);
    u_ctl.step(2);
    rs_p = a + 9'h002;
    apb(0, roi_addr_pkg::OFF_ROW_PTR, 0);
    check("row_ptrs", q, {7'h0, rs_p, 7'h0, a});
    u_ctl.load(1, roi_addr_pkg::LAST_ROW);
    u_ctl.preset(1);
    check("flag_idle", readrow_end_flag_n, 1'b1);
    u_ctl.step(1);
    check("wrap", {readrow_end_flag_n, row_sel_addr}, 10'h000);
    u_ctl.step(1);
    check("flag_end", readrow_end_flag_n, 1'b1);
    u_ctl.preset(2);
    u_ctl.step(2);
    check("rs_wrap", resetrow_end_flag_n, 1'b0);
    rs_p = 9'h000;
    rd_p = 9'h001;
    a = 9'($urandom);
    u_ctl.load(0, a);
    apb(0, roi_addr_pkg::OFF_COL_START, 0);
    check("col_start", q, 32'(a));
    u_ctl.preset(0);
    u_ctl.clk_r[0] <= 1'b0;
    u_ctl.tick();
    check("hold", out_hold, 1'b1);
    u_ctl.clk_r[0] <= 1'b1;
    u_ctl.tick();
    check("run", out_hold, 1'b0);
    check("col_out", col_ptr, nxt(a, roi_addr_pkg::LAST_COL));
    e = (a != roi_addr_pkg::LAST_COL);
    check("col_flag", col_end_flag_n, 32'(e));
    u_ctl.load(0, roi_addr_pkg::LAST_COL);
    u_ctl.preset(0);
    u_ctl.step(0);
    check("col_wrap", {col_end_flag_n, col_ptr}, 10'h000);
    // Every pin pattern against random control bits, both bits set for the last
    for (int i = 0; i < 16; i++) begin
      c = (i == 15) ? 2'h3 : 2'($urandom);
      apb(1, roi_addr_pkg::OFF_CTRL, 32'(c));
      u_ctl.set_ctl(4'(i));
      check("acts", {row_sel_active, row_rst_active, amp_zero_mode},
            act(4'(i), c));
      check("side", row_sel_addr, i[1] ? rd_p : rs_p);
    end
    stop_test();
  end
endmodule
bind pixel_array_addressing_control addr_ctl_asserts u_chk (.*);
